// [hw/dscp_pkg.sv]
// shared constants and types of the dual serial control port
package dscp_pkg;

  // register space geometry
  localparam int ADDR_W = 13;                 // decoded address bits
  localparam int REG_DEPTH = 32;              // bytes actually backed by storage
  localparam logic [12:0] REG_TOP = 13'h0020; // first unbacked address

  // fixed register addresses
  localparam logic [12:0] ADR_CFG = 13'h0000;   // port configuration, acts at once
  localparam logic [12:0] ADR_RDSEL = 13'h0001; // readback source select
  localparam logic [12:0] ADR_UPD = 13'h000F;   // self-clearing transfer strobe
  localparam logic [12:0] UNBUF_TOP = 13'h0010; // below this, writes act at once

  // field positions
  localparam int CFG_LSB_LO = 1;  // lsb-first, low mirror
  localparam int CFG_LSB_HI = 6;  // lsb-first, high mirror
  localparam int CFG_ASC_LO = 2;  // address ascension, low mirror
  localparam int CFG_ASC_HI = 5;  // address ascension, high mirror
  localparam int CFG_SDO_LO = 3;  // dedicated output enable, low mirror
  localparam int CFG_SDO_HI = 4;  // dedicated output enable, high mirror
  localparam int RDSEL_BIT = 5;   // 1 = read active copy
  localparam int UPD_BIT = 0;     // transfer strobe bit

  // serial framing
  localparam logic [4:0] INSTR_LAST = 5'h0F;  // index of the 16th instruction bit
  localparam int INSTR_RW_BIT = 15;           // read/write flag position
  localparam logic [2:0] BIT_LAST = 3'h7;     // last bit index of a byte
  localparam logic [3:0] I2C_BYTE_BITS = 4'h8; // bits per two-wire byte
  localparam logic [4:0] I2C_ADDR_HI = 5'h15; // fixed upper slave address bits
  localparam logic [1:0] STRAP_SPI = 2'h0;    // strap code selecting the four-wire port
  localparam logic [1:0] STRAP_SETTLE = 2'h3; // cycles before straps are trusted
  localparam logic [7:0] BYTE_ZERO = 8'h00;   // unbacked addresses read this

  // storage image
  typedef logic [REG_DEPTH-1:0][7:0] dscp_mem_t;

  // one register write request
  typedef struct packed {
    logic [12:0] addr;
    logic [7:0] data;
  } dscp_wr_t;

  // decoded port configuration
  typedef struct packed {
    logic lsb_first;
    logic ascend;
    logic four_wire;
    logic rd_active;
  } dscp_cfg_t;

  // four-wire port phases
  typedef enum logic [1:0] {
    SP_INSTR = 2'b00,
    SP_WRITE = 2'b01,
    SP_READ = 2'b10
  } dscp_spi_st_t;

  // two-wire slave states
  typedef enum logic [2:0] {
    I2_IDLE = 3'b000,
    I2_RXB = 3'b001,
    I2_TXACK = 3'b010,
    I2_TXB = 3'b011,
    I2_RXACK = 3'b100
  } dscp_i2c_st_t;

  // meaning of the byte being received
  typedef enum logic [1:0] {
    K_DEV = 2'b00,
    K_AH = 2'b01,
    K_AL = 2'b10,
    K_WD = 2'b11
  } dscp_kind_t;

endpackage

// [hw/dscp_top.sv]
`timescale 1ns/1ps
// Operation
// RL1: sixteen-bit instruction first, then payload bytes
// RL2: top bit read/write, fifteen address bits follow
// RL3: address bits fourteen and thirteen forced zero
// RL4: write bits captured on rising serial clock
// RL5: bit zero at 0x000F strobes, self-clears
// RL6: buffered values act only after strobe copy
// RL7: read shifts eight bits per byte out
// RL8: read bits driven on falling edge
// RL9: readback never skips any consecutive address
// RL10: bit five at 0x0001 picks readback source
// RL11: msb first default, bits 1,6 flip order
// RL12: ascension bits zero: address decrements per byte (four-wire port only; two-wire address always increments)
// RL13: ascension bits one: address increments per byte
// RL14: multibyte writes touch every address, none skipped
// RL15: two-wire slave only, sixteen-bit register address
// RL16: no spike filtering on two-wire inputs
// RL17: answer only our seven-bit slave address
// RL18: data changes only while clock low
// RL19: start and stop marked while clock high
// RL20: eight bits msb first plus acknowledge
// RL21: receiver pulls data low to acknowledge
// RL22: not-acknowledge returns slave to idle
// RL23: transfer ends only when chip select rises
// RL24: data outputs released while chip select high
// RL25: straps pick port and two-wire address
// RL26: two-wire write: address high, low, then data
module dscp_top (
  // core clock and reset
  input wire logic core_clk_i,
  input wire logic arst_n_i,
  // four-wire port, serial clock is its own domain
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic sdio_i,
  output logic sdio_o,
  output logic sdio_oe_o,
  output logic serial_data_out_o,
  output logic serial_data_out_oe_o,
  // two-wire port, open drain
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  // port selection straps
  input wire logic port_select_strap0_i,
  input wire logic port_select_strap1_i,
  // towards the controlled logic
  output dscp_pkg::dscp_mem_t act_regs_o,
  output logic update_strobe_o,
  output logic port_ready_o,
  output logic port_is_spi_o
);
  import dscp_pkg::*;

  // byte lookup shared by both ports; unbacked addresses read zero
  function automatic logic [7:0] rd_fn(input logic [12:0] a, input logic sel_act,
                                       input dscp_mem_t bm, input dscp_mem_t am);
    logic [7:0] v;
    v = BYTE_ZERO;
    if (a < REG_TOP) begin
      v = sel_act ? am[a[4:0]] : bm[a[4:0]];
    end
    return v;
  endfunction

  // one serial bit into a byte, either order
  function automatic logic [7:0] sh8(input logic [7:0] v, input logic d, input logic lsb);
    return lsb ? {d, v[7:1]} : {v[6:0], d};
  endfunction

  // core-domain state
  dscp_mem_t buf_mem_r;          // pending values written by the host
  dscp_mem_t act_mem_r;          // values that steer the device
  logic upd_r;                   // transfer strobe pulse
  logic [1:0] strap_s1_r;        // strap synchroniser, first stage
  logic [1:0] strap_s2_r;        // strap synchroniser, second stage
  logic [1:0] settle_r;          // wait before trusting straps
  logic ready_r;                 // straps captured
  logic spi_mode_r;              // four-wire port selected
  logic [1:0] strap_lo_r;        // low slave address bits
  dscp_cfg_t cfg;                // decoded configuration

  // four-wire domain state
  dscp_spi_st_t sp_st_r;         // frame phase
  logic [4:0] icnt_r;            // instruction bit count
  logic [15:0] instr_r;          // instruction shift register
  logic [12:0] sp_addr_r;        // streaming address
  logic [7:0] sp_byte_r;         // payload shift register
  logic [2:0] bidx_r;            // bit index inside payload byte
  logic frm_lsb_r;               // order latched at frame start
  dscp_wr_t sp_hold_r;           // last complete written byte
  logic sp_tgl_r;                // flips once per written byte
  logic sdo_r;                   // read bit, falling-edge timed

  // crossing of the write toggle into the core domain
  logic tgl_s1_r;
  logic tgl_s2_r;
  logic tgl_s3_r;

  // two-wire state
  logic scl_s1_r;
  logic scl_s2_r;
  logic scl_p_r;
  logic sda_s1_r;
  logic sda_s2_r;
  logic sda_p_r;
  dscp_i2c_st_t i2_st_r;
  dscp_kind_t kind_r;
  logic [3:0] i2_cnt_r;
  logic [7:0] i2_sr_r;
  logic rw_r;
  logic [7:0] ah_r;
  logic [15:0] i2_addr_r;
  logic sda_oe_r;
  logic i2_wr_en_r;
  dscp_wr_t i2_wr_r;

  // configuration decode; both mirrors of a field must agree to switch it
  assign cfg.lsb_first = act_mem_r[ADR_CFG[4:0]][CFG_LSB_LO] & act_mem_r[ADR_CFG[4:0]][CFG_LSB_HI]; // see RL11
  assign cfg.ascend = act_mem_r[ADR_CFG[4:0]][CFG_ASC_LO] & act_mem_r[ADR_CFG[4:0]][CFG_ASC_HI]; // see RL12
  assign cfg.four_wire = act_mem_r[ADR_CFG[4:0]][CFG_SDO_LO] & act_mem_r[ADR_CFG[4:0]][CFG_SDO_HI];
  assign cfg.rd_active = act_mem_r[ADR_RDSEL[4:0]][RDSEL_BIT]; // see RL10

  // ---------------- strap capture ----------------

  // straps are pins: two flops, then a short settle before capture
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      strap_s1_r <= 2'h0;
      strap_s2_r <= 2'h0;
    end else begin
      strap_s1_r <= {port_select_strap1_i, port_select_strap0_i};
      strap_s2_r <= strap_s1_r;
    end
  end

  // port choice is frozen until the next reset
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      settle_r <= 2'h0;
      ready_r <= 1'b0;
      spi_mode_r <= 1'b0;
      strap_lo_r <= 2'h0;
    end else if (!ready_r) begin
      settle_r <= settle_r + 2'h1;
      if (settle_r == STRAP_SETTLE) begin
        ready_r <= 1'b1;
        spi_mode_r <= (strap_s2_r == STRAP_SPI); // see RL25
        strap_lo_r <= strap_s2_r;                 // see RL25
      end
    end
  end

  // ---------------- four-wire port, serial clock domain ----------------

  // frame reset: chip select high ends any transfer, no byte count
  wire frame_rst_n = arst_n_i & ~cs_n_i; // see RL23
  // bit order for the current edge; the first edge still reads the live setting
  wire ord_lsb = (sp_st_r == SP_INSTR && icnt_r == 5'h00) ? cfg.lsb_first : frm_lsb_r; // see RL11
  // next values of the shifters
  wire [15:0] instr_nxt = ord_lsb ? {sdio_i, instr_r[15:1]} : {instr_r[14:0], sdio_i};
  wire [7:0] byte_nxt = sh8(sp_byte_r, sdio_i, ord_lsb);
  // streaming address step, wraps inside thirteen bits
  wire [12:0] sp_addr_step = cfg.ascend ? sp_addr_r + 13'h0001 : sp_addr_r - 13'h0001; // see RL12 see RL13
  wire byte_done = (bidx_r == BIT_LAST);
  // byte at the current streaming address
  wire [7:0] sp_rd_byte = rd_fn(sp_addr_r, cfg.rd_active, buf_mem_r, act_mem_r);

  // frame sequencer on rising serial clock
  always_ff @(posedge sclk_i or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      sp_st_r <= SP_INSTR;
      icnt_r <= 5'h00;
      instr_r <= 16'h0000;
      sp_addr_r <= 13'h0000;
      sp_byte_r <= 8'h00;
      bidx_r <= 3'h0;
      frm_lsb_r <= 1'b0;
    end else begin
      unique case (sp_st_r)
        SP_INSTR: begin
          // sixteen edges of instruction, then the payload
          instr_r <= instr_nxt; // see RL1
          icnt_r <= icnt_r + 5'h01;
          if (icnt_r == 5'h00) begin
            frm_lsb_r <= cfg.lsb_first;
          end
          if (icnt_r == INSTR_LAST) begin
            sp_addr_r <= instr_nxt[12:0]; // see RL3
            sp_st_r <= instr_nxt[INSTR_RW_BIT] ? SP_READ : SP_WRITE; // see RL2
            bidx_r <= 3'h0;
          end
        end
        SP_WRITE: begin
          // payload bits taken on the rising edge
          sp_byte_r <= byte_nxt; // see RL4
          bidx_r <= bidx_r + 3'h1;
          if (byte_done) begin
            sp_addr_r <= sp_addr_step; // see RL14
          end
        end
        SP_READ: begin
          // eight bits per byte, then the next address
          bidx_r <= bidx_r + 3'h1; // see RL7
          if (byte_done) begin
            sp_addr_r <= sp_addr_step; // see RL9
          end
        end
      endcase
    end
  end

  // completed write bytes survive the frame end, so only the power reset clears them
  always_ff @(posedge sclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sp_hold_r <= '0;
      sp_tgl_r <= 1'b0;
    end else if (!cs_n_i && sp_st_r == SP_WRITE && byte_done) begin
      sp_hold_r.addr <= sp_addr_r; // see RL14
      sp_hold_r.data <= byte_nxt;  // see RL4
      sp_tgl_r <= ~sp_tgl_r;
    end
  end

  // read bit launched on the falling edge, host samples on the next rise
  always_ff @(negedge sclk_i or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      sdo_r <= 1'b0;
    end else if (sp_st_r == SP_READ) begin
      sdo_r <= ord_lsb ? sp_rd_byte[bidx_r] : sp_rd_byte[~bidx_r]; // see RL8
    end else begin
      sdo_r <= 1'b0;
    end
  end

  // outputs float whenever chip select is high or no read is running
  wire sp_drive = spi_mode_r & ~cs_n_i & (sp_st_r == SP_READ); // see RL24
  assign sdio_o = sdo_r;
  assign sdio_oe_o = sp_drive & ~cfg.four_wire;
  assign serial_data_out_o = sdo_r;
  assign serial_data_out_oe_o = sp_drive & cfg.four_wire;

  // ---------------- crossing of written bytes ----------------

  // toggle synchroniser; the hold word is stable for a whole byte time
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      tgl_s1_r <= 1'b0;
      tgl_s2_r <= 1'b0;
      tgl_s3_r <= 1'b0;
    end else begin
      tgl_s1_r <= sp_tgl_r;
      tgl_s2_r <= tgl_s1_r;
      tgl_s3_r <= tgl_s2_r;
    end
  end

  wire sp_wr_pulse = tgl_s2_r ^ tgl_s3_r;

  // ---------------- register storage ----------------

  // one write port, fed by whichever port the straps chose
  wire wr_en = spi_mode_r ? sp_wr_pulse : i2_wr_en_r;
  dscp_wr_t wr;
  assign wr = spi_mode_r ? sp_hold_r : i2_wr_r;
  wire wr_backed = wr_en & (wr.addr < REG_TOP);
  wire wr_direct = wr.addr < UNBUF_TOP;
  wire wr_is_upd = wr.addr == ADR_UPD;
  // the strobe bit never stores, so it always reads back zero
  wire [7:0] wr_data = wr_is_upd ? (wr.data & ~(8'h01 << UPD_BIT)) : wr.data;

  // buffer copy; a write simply lands here
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      buf_mem_r <= '0;
    end else if (wr_backed) begin
      buf_mem_r[wr.addr[4:0]] <= wr_data;
    end
  end

  // active copy: whole buffer on the strobe, low control bytes at once
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      act_mem_r <= '0;
    end else begin
      if (upd_r) begin
        act_mem_r <= buf_mem_r; // see RL6
      end
      // a write below 0x0010 in the copy cycle overrides its own byte
      if (wr_backed && wr_direct) begin
        act_mem_r[wr.addr[4:0]] <= wr_data;
      end
    end
  end

  // strobe pulse, one core cycle, cleared by itself
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      upd_r <= 1'b0;
    end else begin
      upd_r <= wr_en & wr_is_upd & wr.data[UPD_BIT]; // see RL5
    end
  end

  assign act_regs_o = act_mem_r;
  assign update_strobe_o = upd_r;
  assign port_ready_o = ready_r;
  assign port_is_spi_o = spi_mode_r;

  // ---------------- two-wire port, core clock domain ----------------

  // plain two-flop sampling; no spike filter, so glitches are seen as edges
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      scl_s1_r <= 1'b1;
      scl_s2_r <= 1'b1;
      scl_p_r <= 1'b1;
      sda_s1_r <= 1'b1;
      sda_s2_r <= 1'b1;
      sda_p_r <= 1'b1;
    end else begin
      scl_s1_r <= scl_i; // see RL16
      scl_s2_r <= scl_s1_r;
      scl_p_r <= scl_s2_r;
      sda_s1_r <= sda_i;
      sda_s2_r <= sda_s1_r;
      sda_p_r <= sda_s2_r;
    end
  end

  // bus events
  wire scl_rise = scl_s2_r & ~scl_p_r;
  wire scl_fall = ~scl_s2_r & scl_p_r;
  wire bus_start = scl_s2_r & scl_p_r & sda_p_r & ~sda_s2_r; // see RL19
  wire bus_stop = scl_s2_r & scl_p_r & ~sda_p_r & sda_s2_r;  // see RL19
  wire i2_active = ready_r & ~spi_mode_r;
  wire byte_full = (i2_cnt_r == I2C_BYTE_BITS);
  wire addr_match = (i2_sr_r[7:1] == {I2C_ADDR_HI, strap_lo_r}); // see RL17
  wire [7:0] i2_rd_byte = rd_fn(i2_addr_r[12:0], cfg.rd_active, buf_mem_r, act_mem_r);
  wire [15:0] i2_addr_inc = i2_addr_r + 16'h0001;

  // slave sequencer; start or stop wins over any byte in progress
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      i2_st_r <= I2_IDLE;
      kind_r <= K_DEV;
      i2_cnt_r <= 4'h0;
      i2_sr_r <= 8'h00;
      rw_r <= 1'b0;
      ah_r <= 8'h00;
      i2_addr_r <= 16'h0000;
      sda_oe_r <= 1'b0;
      i2_wr_en_r <= 1'b0;
      i2_wr_r <= '0;
    end else begin
      i2_wr_en_r <= 1'b0;
      if (!i2_active || bus_stop) begin
        // stop or wrong port: release the line, partial byte dropped
        i2_st_r <= I2_IDLE;
        sda_oe_r <= 1'b0;
      end else if (bus_start) begin
        // start or repeated start: expect the slave address
        i2_st_r <= I2_RXB;
        kind_r <= K_DEV;
        i2_cnt_r <= 4'h0;
        sda_oe_r <= 1'b0;
      end else begin
        unique case (i2_st_r)
          I2_IDLE: begin
            sda_oe_r <= 1'b0;
          end
          I2_RXB: begin
            // bits are taken while clock is high, msb first
            if (scl_rise) begin
              i2_sr_r <= {i2_sr_r[6:0], sda_s2_r}; // see RL18 see RL20
              i2_cnt_r <= i2_cnt_r + 4'h1;
            end else if (scl_fall && byte_full) begin
              i2_cnt_r <= 4'h0;
              i2_st_r <= I2_TXACK;
              sda_oe_r <= 1'b1; // see RL21
              unique case (kind_r)
                K_DEV: begin
                  rw_r <= i2_sr_r[0];
                  if (!addr_match) begin
                    // not ours: stay off the bus
                    i2_st_r <= I2_IDLE; // see RL17
                    sda_oe_r <= 1'b0;
                  end
                end
                K_AH: ah_r <= i2_sr_r; // see RL26
                K_AL: i2_addr_r <= {ah_r, i2_sr_r}; // see RL15 see RL26
                K_WD: begin
                  i2_wr_en_r <= 1'b1;
                  i2_wr_r.addr <= i2_addr_r[12:0];
                  i2_wr_r.data <= i2_sr_r;
                  i2_addr_r <= i2_addr_inc;
                end
              endcase
            end
          end
          I2_TXACK: begin
            // acknowledge held through the ninth pulse
            if (scl_fall) begin
              if (kind_r == K_DEV && rw_r) begin
                i2_st_r <= I2_TXB;
                i2_sr_r <= i2_rd_byte;
                sda_oe_r <= ~i2_rd_byte[7]; // see RL18
                i2_cnt_r <= 4'h0;
              end else begin
                i2_st_r <= I2_RXB;
                sda_oe_r <= 1'b0;
                kind_r <= (kind_r == K_DEV) ? K_AH : (kind_r == K_AH) ? K_AL : K_WD; // see RL26
              end
            end
          end
          I2_TXB: begin
            // data changes only after a falling clock
            if (scl_rise) begin
              i2_cnt_r <= i2_cnt_r + 4'h1;
            end else if (scl_fall) begin
              if (byte_full) begin
                i2_st_r <= I2_RXACK;
                sda_oe_r <= 1'b0;
                i2_addr_r <= i2_addr_inc;
              end else begin
                i2_sr_r <= {i2_sr_r[6:0], 1'b0};
                sda_oe_r <= ~i2_sr_r[6]; // see RL20
              end
            end
          end
          I2_RXACK: begin
            // master leaves data high: transfer over
            if (scl_rise && sda_s2_r) begin
              i2_st_r <= I2_IDLE; // see RL22
            end else if (scl_fall) begin
              i2_st_r <= I2_TXB;
              i2_sr_r <= i2_rd_byte;
              sda_oe_r <= ~i2_rd_byte[7];
              i2_cnt_r <= 4'h0;
            end
          end
          default: begin
            i2_st_r <= I2_IDLE;
            sda_oe_r <= 1'b0;
          end
        endcase
      end
    end
  end

  // never drives high and never drives the clock line
  assign sda_o = 1'b0; // see RL15
  assign sda_oe_o = sda_oe_r;

endmodule // dscp_top

// [verification/dscp_top_sva.sv]
`timescale 1ns/1ps
// port-level checks of the dual serial control port
module dscp_top_sva (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic arst_n_i,
  // watched pins
  input wire logic cs_n_i,
  input wire logic sdio_oe_o,
  input wire logic serial_data_out_oe_o,
  input wire logic sda_o,
  input wire logic sda_oe_o,
  // towards the controlled logic
  input dscp_pkg::dscp_mem_t act_regs_o,
  input wire logic update_strobe_o,
  input wire logic port_ready_o,
  input wire logic port_is_spi_o
);
  import dscp_pkg::*;
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!arst_n_i);
  // strobe is one core cycle wide
  sequence s_one_pulse;
    update_strobe_o ##1 !update_strobe_o;
  endsequence
  property p_strobe_pulse; $rose(update_strobe_o) |-> s_one_pulse; endproperty
  a_strobe_pulse: assert property (p_strobe_pulse) else $error("strobe wider than one cycle");
  // buffered half moves only with the strobe
  property p_buf_hold;
    $changed(act_regs_o[31:16]) |-> (update_strobe_o || $past(update_strobe_o) || $past(update_strobe_o, 2));
  endproperty
  a_buf_hold: assert property (p_buf_hold) else $error("buffered register acted without strobe");
  property p_cs_release; (cs_n_i || !port_is_spi_o) |-> (!sdio_oe_o && !serial_data_out_oe_o); endproperty
  a_cs_release: assert property (p_cs_release) else $error("data out driven while deselected");
  property p_oe_excl; !(sdio_oe_o && serial_data_out_oe_o); endproperty
  a_oe_excl: assert property (p_oe_excl) else $error("both data outputs driven");
  property p_sda_zero; sda_o == 1'b0; endproperty
  a_sda_zero: assert property (p_sda_zero) else $error("sda driven high");
  property p_no_ack_spi; port_is_spi_o |-> !sda_oe_o; endproperty
  a_no_ack_spi: assert property (p_no_ack_spi) else $error("two-wire active in four-wire mode");
  // straps settle within a few cycles, then the choice is frozen
  property p_ready_soon; !port_ready_o |-> ##[0:8] port_ready_o; endproperty
  a_ready_soon: assert property (p_ready_soon) else $error("port never became ready");
  property p_port_frozen; port_ready_o |=> (port_ready_o && $stable(port_is_spi_o)); endproperty
  a_port_frozen: assert property (p_port_frozen) else $error("port choice changed");
  c_strobe: cover property (update_strobe_o);
endmodule // dscp_top_sva
bind dscp_top dscp_top_sva i_sva (.core_clk_i(core_clk_i), .arst_n_i(arst_n_i), .cs_n_i(cs_n_i),
  .sdio_oe_o(sdio_oe_o), .serial_data_out_oe_o(serial_data_out_oe_o), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
  .act_regs_o(act_regs_o), .update_strobe_o(update_strobe_o), .port_ready_o(port_ready_o),
  .port_is_spi_o(port_is_spi_o));

// [verification/dscp_spi_host.sv]
`timescale 1ns/1ps
// behavioural serial host, 12 ns serial clock, idle low between frames
module dscp_spi_host (
  // host pins
  output logic sclk_o,
  output logic cs_n_o,
  output logic sdio_drv_o,
  // resolved data line
  input wire logic line_i
);
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    sdio_drv_o = 1'b0;
  end
  // data changes while sclk low, sampled at the rise
  task automatic shift(input logic [15:0] tx, input int nb, input bit lsb, input bit drv, output logic [15:0] rx);
    rx = 16'h0000;
    for (int i = 0; i < nb; i++) begin
      // released line toggles so a stale value never reads as valid
      sdio_drv_o = drv ? tx[lsb ? i : nb - 1 - i] : ~sdio_drv_o;
      #6 sclk_o = 1'b1;
      rx[lsb ? i : nb - 1 - i] = line_i;
      #6 sclk_o = 1'b0;
    end
  endtask
  // instruction then n payload bytes, byte b at bits 8b+7..8b
  task automatic frame(input bit rd, input logic [14:0] a, input int n, input bit lsb, input logic [31:0] wd,
    output logic [31:0] rq);
    logic [15:0] rx;
    rq = 32'h00000000;
    cs_n_o = 1'b0;
    #6;
    shift({rd, a}, 16, lsb, 1'b1, rx);
    for (int b = 0; b < n; b++) begin
      shift({8'h00, wd[8*b+:8]}, 8, lsb, !rd, rx);
      rq[8*b+:8] = rx[7:0];
    end
    // stream ends only at deselect; gap lets writes land
    #6 cs_n_o = 1'b1;
    #100;
  endtask
endmodule // dscp_spi_host

// [verification/dscp_top_bench.sv]
`timescale 1ns/1ps
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin err_total++; \
  $display("ERROR t=%0t got=%0h exp=%0h", $time, (got), (exp)); end end
module dscp_top_bench;
  import dscp_pkg::*;
  logic core_clk_i, arst_n_i, strap0, strap1, scl_m, sda_m, sda_i_r;
  logic sdio_o, sdio_oe_o, serial_data_out, sdo_oe, sda_o, sda_oe_o, upd, rdy, is_spi, sclk, cs_n, host_sdio, ack;
  logic [31:0] q;
  dscp_mem_t act;
  int err_total = 0;
  int checks_done = 0;
  // resolved lines: dut drive wins, sda has a pull-up
  wire sdio_w = sdio_oe_o ? sdio_o : host_sdio;
  wire line_w = sdo_oe ? serial_data_out : sdio_w;
  wire sda_w = (sda_oe_o ? sda_o : 1'b1) & sda_m;
  always @(posedge core_clk_i) sda_i_r <= sda_w;
  dscp_top i_dut (.core_clk_i(core_clk_i), .arst_n_i(arst_n_i), .sclk_i(sclk), .cs_n_i(cs_n),
    .sdio_i(sdio_w), .sdio_o(sdio_o), .sdio_oe_o(sdio_oe_o), .serial_data_out_o(serial_data_out),
    .serial_data_out_oe_o(sdo_oe), .scl_i(scl_m), .sda_i(sda_i_r), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
    .port_select_strap0_i(strap0), .port_select_strap1_i(strap1), .act_regs_o(act),
    .update_strobe_o(upd), .port_ready_o(rdy), .port_is_spi_o(is_spi));
  dscp_spi_host i_host (.sclk_o(sclk), .cs_n_o(cs_n), .sdio_drv_o(host_sdio), .line_i(line_w));
  initial begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end
  task automatic wait_c(input int n);
    repeat (n) @(posedge core_clk_i);
  endtask
  // reset with given straps, then bounded wait for ready
  task automatic do_reset(input logic [1:0] s);
    arst_n_i <= 1'b0;
    {strap1, strap0} <= s;
    wait_c(16);
    arst_n_i <= 1'b1;
    for (int i = 0; i < 20 && rdy !== 1'b1; i++) wait_c(1);
  endtask
  // one two-wire bit, level sampled mid-high
  task automatic i2c_bit(input logic b, output logic s);
    wait_c(20); sda_m <= b;
    wait_c(20); scl_m <= 1'b1;
    wait_c(20); s = sda_w;
    wait_c(20); scl_m <= 1'b0;
  endtask
  // start or repeated start, both lines raised first
  task automatic i2c_start;
    wait_c(20);
    sda_m <= 1'b1;
    wait_c(20);
    scl_m <= 1'b1;
    wait_c(20);
    sda_m <= 1'b0;
    wait_c(20);
    scl_m <= 1'b0;
  endtask
  task automatic i2c_stop;
    wait_c(20);
    sda_m <= 1'b0;
    wait_c(20);
    scl_m <= 1'b1;
    wait_c(20);
    sda_m <= 1'b1;
  endtask
  // eight bits msb first, line levels into r, then ninth bit n
  task automatic i2c_byte(input logic [7:0] v, input logic n, output logic [7:0] r, output logic acked);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      i2c_bit(v[i], s);
      r[i] = s;
    end
    i2c_bit(n, s);
    acked = !s;
  endtask
  // buffered writes, ascending stream, strobe copy
  task automatic t_write_update;
    i_host.frame(1'b0, 15'h0000, 1, 1'b0, 32'h24, q);
    `CHK(act[0], 8'h24)
    i_host.frame(1'b0, 15'h0010, 2, 1'b0, 32'h5AA5, q);
    `CHK(act[16], 8'h00)
    i_host.frame(1'b0, 15'h000F, 1, 1'b0, 32'h01, q);
    `CHK(act[16], 8'hA5)
    `CHK(act[17], 8'h5A)
    $display("test write_update done");
  endtask
  // readback through blank byte, source select
  task automatic t_read;
    i_host.frame(1'b1, 15'h0010, 3, 1'b0, 32'h0, q);
    `CHK(q[23:0], 24'h005AA5)
    i_host.frame(1'b0, 15'h0012, 1, 1'b0, 32'h77, q);
    i_host.frame(1'b1, 15'h0012, 1, 1'b0, 32'h0, q);
    `CHK(q[7:0], 8'h77)
    i_host.frame(1'b0, 15'h0001, 1, 1'b0, 32'h20, q);
    i_host.frame(1'b1, 15'h0012, 1, 1'b0, 32'h0, q);
    `CHK(q[7:0], 8'h00)
    $display("test read done");
  endtask
  // descending stream, top address bits ignored
  task automatic t_decr;
    i_host.frame(1'b0, 15'h0000, 1, 1'b0, 32'h00, q);
    i_host.frame(1'b1, 15'h6011, 2, 1'b0, 32'h0, q);
    `CHK(q[15:0], 16'hA55A)
    $display("test decr done");
  endtask
  // lsb first from the following frame, read on the dedicated output
  task automatic t_lsb;
    i_host.frame(1'b0, 15'h0000, 1, 1'b0, 32'h7E, q);
    i_host.frame(1'b1, 15'h0010, 2, 1'b1, 32'h0, q);
    `CHK(q[15:0], 16'h5AA5)
    $display("test lsb done");
  endtask
  // two-wire port: other address ignored, write, read back, not-acknowledge ends the read
  task automatic t_i2c;
    logic [7:0] r;
    do_reset(2'b01);
    `CHK(is_spi, 1'b0)
    i2c_start();
    i2c_byte(8'hAC, 1'b1, r, ack);
    `CHK(ack, 1'b0)
    i2c_stop();
    i2c_start();
    i2c_byte(8'hAA, 1'b1, r, ack);
    `CHK(ack, 1'b1)
    i2c_byte(8'h00, 1'b1, r, ack);
    i2c_byte(8'h10, 1'b1, r, ack);
    i2c_byte(8'h3C, 1'b1, r, ack);
    `CHK(ack, 1'b1)
    i2c_stop();
    i2c_start();
    i2c_byte(8'hAA, 1'b1, r, ack);
    i2c_byte(8'h00, 1'b1, r, ack);
    i2c_byte(8'h10, 1'b1, r, ack);
    i2c_start();
    i2c_byte(8'hAB, 1'b1, r, ack);
    i2c_byte(8'hFF, 1'b1, r, ack);
    `CHK(r, 8'h3C)
    i2c_byte(8'hFF, 1'b1, r, ack);
    `CHK(r, 8'hFF)
    i2c_stop();
    $display("test i2c done");
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    arst_n_i = 1'b0;
    strap0 = 1'b0;
    strap1 = 1'b0;
    scl_m = 1'b1;
    sda_m = 1'b1;
    do_reset(2'b00);
    `CHK(is_spi, 1'b1)
    t_write_update();
    t_read();
    t_decr();
    t_lsb();
    t_i2c();
    end_of_test();
  end
  // watchdog about three times the expected ninety microseconds
  initial begin
    #300000;
    err_total++;
    end_of_test();
  end
endmodule // dscp_top_bench
